// File: flash_cmd_map.svh
// register offsets, field positions, reset values and timing counts of the flash command unit
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

// register byte offsets
`define FCU_OFF_MODE 8'h60
`define FCU_OFF_CMD 8'h64
`define FCU_OFF_STATUS 8'h68

// command word fields
`define FCU_KEY_MSB 31
`define FCU_KEY_LSB 24
`define FCU_KEY_VALUE 8'h5a
`define FCU_PAGE_MSB 17
`define FCU_PAGE_LSB 8
`define FCU_CODE_MSB 3
`define FCU_CODE_LSB 0

// status word bit positions
`define FCU_ST_READY 0
`define FCU_ST_LOCK_ERR 2
`define FCU_ST_PROG_ERR 3
`define FCU_ST_SECURITY 4
`define FCU_ST_GP_LSB 8
`define FCU_ST_LOCK_LSB 16

// mode register interrupt enable positions
`define FCU_EN_READY 0
`define FCU_EN_LOCK_ERR 2
`define FCU_EN_PROG_ERR 3
`define FCU_MODE_RESET 32'h0000_0000

// array geometry
`define FCU_PAGE_BITS 10
`define FCU_REGION_BITS 4
`define FCU_REGIONS 16
`define FCU_GP_BITS 3

// timing
`define FCU_CLK_MHZ 125
`define FCU_PAGE_PROG_TIME_US 6000
`define FCU_ERASE_ALL_TIME_US 15000
`define FCU_NVM_TIME_US 1
`define FCU_PAGE_PROG_CYCLES (`FCU_PAGE_PROG_TIME_US * `FCU_CLK_MHZ)
`define FCU_ERASE_ALL_CYCLES (`FCU_ERASE_ALL_TIME_US * `FCU_CLK_MHZ)
`define FCU_NVM_CYCLES (`FCU_NVM_TIME_US * `FCU_CLK_MHZ)

`endif

// File: flash_cmd_pkg.sv
// types shared by the flash command unit
package flash_cmd_pkg;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_WRITE_PAGE = 4'h1,
    CMD_SET_LOCK = 4'h2,
    CMD_WRITE_PAGE_LOCK = 4'h3,
    CMD_CLEAR_LOCK = 4'h4,
    CMD_ERASE_ALL = 4'h8,
    CMD_SET_GP_BIT = 4'hb,
    CMD_CLEAR_GP_BIT = 4'hd,
    CMD_SET_SECURITY = 4'hf
  } cmd_code_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROG = 3'b001,
    ST_LOCK = 3'b010,
    ST_UNLOCK = 3'b011,
    ST_ERASE = 3'b100,
    ST_GP_SET = 3'b101,
    ST_GP_CLEAR = 3'b110,
    ST_SECURE = 3'b111
  } state_e;

endpackage

// File: flash_command_status_unit.sv
// command decoder, sequencer and status register of the embedded flash controller
//
// The plain strobed port was chosen for this implementation.
`include "flash_cmd_map.svh"
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - code zero does nothing and leaves the programming error flag alone
// - code 0001 programs the page named in the page field
// - code 0010 locks the region holding the named page
// - code 0011 programs the page then locks its region automatically
// - code 0100 unlocks the region holding the named page
// - code 1000 erases the whole array, cancelled if any region is locked
// - code 1011 sets the general purpose bit given by the page field
// - code 1101 clears the general purpose bit given by the page field
// - code 1111 sets the security bit; page field ignored here and for erase
// - reserved codes set the programming error flag
// - only key 0x5a makes a command word act; software supplies it
// - unused page bits are ignored; any page of a region selects it
// - ready bit 0 reads 0 while busy and 1 when idle
// - lock error flags a locked-region program attempt, cleared by status read
// - programming error flags a bad key or invalid code
// - status bit 4 shows the security bit
// - status bits 8 to 10 show the general purpose bits
// - status bits 16 up show one lock state per region, 1 locked
// - completion raises ready and, if enabled, the interrupt
// - ready, lock error and programming error each have an interrupt enable
// - a general purpose bit index beyond the implemented bits has no effect
module flash_command_status_unit #(
  parameter int unsigned PROG_CYCLES = `FCU_PAGE_PROG_CYCLES,
  parameter int unsigned ERASE_CYCLES = `FCU_ERASE_ALL_CYCLES,
  parameter int unsigned NVM_CYCLES = `FCU_NVM_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // controller status
  output logic ready_o,
  output logic irq_o,
  // flash array operation strobes
  output logic prog_start_o,
  output logic erase_start_o,
  output logic [`FCU_PAGE_BITS-1:0] page_o
);

  flash_cmd_pkg::state_e state;
  flash_cmd_pkg::state_e next_state;
  logic [31:0] timer;
  logic [`FCU_PAGE_BITS-1:0] cmd_page;
  logic lock_after_prog;
  logic [`FCU_REGIONS-1:0] region_locked;
  logic [`FCU_GP_BITS-1:0] gp_bits;
  logic security;
  logic lock_err;
  logic prog_err;
  logic en_ready;
  logic en_lock_err;
  logic en_prog_err;

  logic cmd_wr;
  logic key_ok;
  logic accept;
  logic bad_cmd;
  logic lock_violation;
  logic status_rd;
  logic op_done;
  flash_cmd_pkg::cmd_code_e code;
  logic [`FCU_PAGE_BITS-1:0] wr_page;
  logic [31:0] status_word;

  // region of a page: upper page bits only, lower bits do not matter
  function automatic logic [`FCU_REGION_BITS-1:0] region_of(input logic [`FCU_PAGE_BITS-1:0] page);
    region_of = page[`FCU_PAGE_BITS-1:`FCU_PAGE_BITS-`FCU_REGION_BITS];
  endfunction

  // code belongs to the defined set
  function automatic logic code_valid(input flash_cmd_pkg::cmd_code_e c);
    case (c)
      flash_cmd_pkg::CMD_NONE,
      flash_cmd_pkg::CMD_WRITE_PAGE,
      flash_cmd_pkg::CMD_SET_LOCK,
      flash_cmd_pkg::CMD_WRITE_PAGE_LOCK,
      flash_cmd_pkg::CMD_CLEAR_LOCK,
      flash_cmd_pkg::CMD_ERASE_ALL,
      flash_cmd_pkg::CMD_SET_GP_BIT,
      flash_cmd_pkg::CMD_CLEAR_GP_BIT,
      flash_cmd_pkg::CMD_SET_SECURITY: code_valid = 1'b1;
      default: code_valid = 1'b0;
    endcase
  endfunction

  // general purpose index check, wide page field compared in full
  function automatic logic gp_index_ok(input logic [`FCU_PAGE_BITS-1:0] page);
    gp_index_ok = (page < `FCU_PAGE_BITS'(`FCU_GP_BITS));
  endfunction

  // cycles minus one spent in a busy state
  function automatic logic [31:0] load_for(input flash_cmd_pkg::state_e s);
    case (s)
      flash_cmd_pkg::ST_PROG: load_for = PROG_CYCLES - 32'd1;
      flash_cmd_pkg::ST_ERASE: load_for = ERASE_CYCLES - 32'd1;
      flash_cmd_pkg::ST_IDLE: load_for = 32'd0;
      default: load_for = NVM_CYCLES - 32'd1;
    endcase
  endfunction

  // command word decode
  assign cmd_wr = wr_i && (addr_i == `FCU_OFF_CMD);
  assign key_ok = (wdata_i[`FCU_KEY_MSB:`FCU_KEY_LSB] == `FCU_KEY_VALUE);
  assign code = flash_cmd_pkg::cmd_code_e'(wdata_i[`FCU_CODE_MSB:`FCU_CODE_LSB]);
  assign wr_page = wdata_i[`FCU_PAGE_MSB:`FCU_PAGE_LSB];
  // a write while busy is dropped, the sequencer cannot queue a second command
  assign accept = cmd_wr && key_ok && (state == flash_cmd_pkg::ST_IDLE);
  assign bad_cmd = cmd_wr && (!key_ok || !code_valid(code));
  assign status_rd = rd_i && (addr_i == `FCU_OFF_STATUS);
  assign op_done = (state != flash_cmd_pkg::ST_IDLE) && (timer == 32'd0);

  // program attempts into a locked region, and erase-all with any lock
  always_comb
  begin
    lock_violation = 1'b0;
    if (accept)
    begin
      case (code)
        flash_cmd_pkg::CMD_WRITE_PAGE,
        flash_cmd_pkg::CMD_WRITE_PAGE_LOCK: lock_violation = region_locked[region_of(wr_page)];
        flash_cmd_pkg::CMD_ERASE_ALL: lock_violation = |region_locked;
        default: lock_violation = 1'b0;
      endcase
    end
  end

  // sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      flash_cmd_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          case (code)
            flash_cmd_pkg::CMD_WRITE_PAGE,
            flash_cmd_pkg::CMD_WRITE_PAGE_LOCK:
            begin
              if (!lock_violation)
              begin
                next_state = flash_cmd_pkg::ST_PROG;
              end
            end
            flash_cmd_pkg::CMD_SET_LOCK: next_state = flash_cmd_pkg::ST_LOCK;
            flash_cmd_pkg::CMD_CLEAR_LOCK: next_state = flash_cmd_pkg::ST_UNLOCK;
            flash_cmd_pkg::CMD_ERASE_ALL:
            begin
              if (!lock_violation)
              begin
                next_state = flash_cmd_pkg::ST_ERASE;
              end
            end
            flash_cmd_pkg::CMD_SET_GP_BIT:
            begin
              if (gp_index_ok(wr_page))
              begin
                next_state = flash_cmd_pkg::ST_GP_SET;
              end
            end
            flash_cmd_pkg::CMD_CLEAR_GP_BIT:
            begin
              if (gp_index_ok(wr_page))
              begin
                next_state = flash_cmd_pkg::ST_GP_CLEAR;
              end
            end
            flash_cmd_pkg::CMD_SET_SECURITY: next_state = flash_cmd_pkg::ST_SECURE;
            default: next_state = flash_cmd_pkg::ST_IDLE;
          endcase
        end
      end
      flash_cmd_pkg::ST_PROG:
      begin
        if (op_done)
        begin
          next_state = lock_after_prog ? flash_cmd_pkg::ST_LOCK : flash_cmd_pkg::ST_IDLE;
        end
      end
      default:
      begin
        if (op_done)
        begin
          next_state = flash_cmd_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= flash_cmd_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // operation timer, reloaded on every state change
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      timer <= 32'd0;
    end
    else if (next_state != state)
    begin
      timer <= load_for(next_state);
    end
    else if (timer != 32'd0)
    begin
      timer <= timer - 32'd1;
    end
  end

  // command operands held for the whole sequence
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_page <= '0;
      lock_after_prog <= 1'b0;
    end
    else if (accept)
    begin
      cmd_page <= wr_page;
      lock_after_prog <= (code == flash_cmd_pkg::CMD_WRITE_PAGE_LOCK);
    end
  end

  // region lock bits, updated when the nvm cycle finishes
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      region_locked <= '0;
    end
    else if (op_done && (state == flash_cmd_pkg::ST_LOCK))
    begin
      region_locked[region_of(cmd_page)] <= 1'b1;
    end
    else if (op_done && (state == flash_cmd_pkg::ST_UNLOCK))
    begin
      region_locked[region_of(cmd_page)] <= 1'b0;
    end
  end

  // general purpose nonvolatile bits
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gp_bits <= '0;
    end
    else if (op_done && (state == flash_cmd_pkg::ST_GP_SET))
    begin
      gp_bits[cmd_page[1:0]] <= 1'b1;
    end
    else if (op_done && (state == flash_cmd_pkg::ST_GP_CLEAR))
    begin
      gp_bits[cmd_page[1:0]] <= 1'b0;
    end
  end

  // security bit; only an external erase could clear it, which lives elsewhere
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      security <= 1'b0;
    end
    else if (op_done && (state == flash_cmd_pkg::ST_SECURE))
    begin
      security <= 1'b1;
    end
  end

  // lock error: a new event wins over the clear by a status read
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lock_err <= 1'b0;
    end
    else if (lock_violation)
    begin
      lock_err <= 1'b1;
    end
    else if (status_rd)
    begin
      lock_err <= 1'b0;
    end
  end

  // programming error: same set-over-clear priority as lock error
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prog_err <= 1'b0;
    end
    else if (bad_cmd)
    begin
      prog_err <= 1'b1;
    end
    else if (status_rd)
    begin
      prog_err <= 1'b0;
    end
  end

  // interrupt enables in the mode register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      en_ready <= 1'(`FCU_MODE_RESET >> `FCU_EN_READY);
      en_lock_err <= 1'b0;
      en_prog_err <= 1'b0;
    end
    else if (wr_i && (addr_i == `FCU_OFF_MODE))
    begin
      en_ready <= wdata_i[`FCU_EN_READY];
      en_lock_err <= wdata_i[`FCU_EN_LOCK_ERR];
      en_prog_err <= wdata_i[`FCU_EN_PROG_ERR];
    end
  end

  // status word assembly; unused bits read zero
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`FCU_ST_READY] = (state == flash_cmd_pkg::ST_IDLE);
    status_word[`FCU_ST_LOCK_ERR] = lock_err;
    status_word[`FCU_ST_PROG_ERR] = prog_err;
    status_word[`FCU_ST_SECURITY] = security;
    status_word[`FCU_ST_GP_LSB +: `FCU_GP_BITS] = gp_bits;
    status_word[`FCU_ST_LOCK_LSB +: `FCU_REGIONS] = region_locked;
  end

  // read data, valid the cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 32'h0000_0000;
    end
    else if (rd_i)
    begin
      case (addr_i)
        `FCU_OFF_STATUS: rdata_o <= status_word;
        `FCU_OFF_MODE: rdata_o <= {28'h0000000, en_prog_err, en_lock_err, 1'b0, en_ready};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end
    else
    begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // array strobes: one pulse as a program or erase phase begins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prog_start_o <= 1'b0;
      erase_start_o <= 1'b0;
      page_o <= '0;
    end
    else
    begin
      prog_start_o <= (next_state == flash_cmd_pkg::ST_PROG) && (state != flash_cmd_pkg::ST_PROG);
      erase_start_o <= (next_state == flash_cmd_pkg::ST_ERASE) && (state != flash_cmd_pkg::ST_ERASE);
      if (accept)
      begin
        page_o <= wr_page;
      end
    end
  end

  // ready and interrupt are levels; the line stays up while any enabled cause is set
  assign ready_o = (state == flash_cmd_pkg::ST_IDLE);
  assign irq_o = (en_ready && ready_o) || (en_lock_err && lock_err) || (en_prog_err && prog_err);

endmodule

`default_nettype wire

// File: flash_command_status_unit_assertions.sv
// concurrent checks on command acceptance, busy timing and status reads of the flash command unit
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_checker #(
  parameter int PROG_CYCLES = 5,
  parameter int ERASE_CYCLES = 7,
  parameter int NVM_CYCLES = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // status and array strobes
  input wire logic ready_o,
  input wire logic irq_o,
  input wire logic prog_start_o,
  input wire logic erase_start_o,
  input wire logic [9:0] page_o
);
  // margins of two cycles allow for the take and the return edge
  localparam int PROG_MAX = PROG_CYCLES + NVM_CYCLES + 2;
  localparam int ERASE_MAX = ERASE_CYCLES + 2;
  localparam int NVM_MAX = NVM_CYCLES + 2;
  logic [9:0] page_held;

  // page field of the word offered one cycle earlier
  always_ff @(posedge clk_i)
    page_held <= wdata_i[17:8];

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // keyed command word offered while idle
  sequence s_take;
    wr_i && addr_i == 8'h64 && wdata_i[31:24] == 8'h5a && ready_o;
  endsequence
  // busy at once, idle again within a bound
  sequence s_busy_nvm;
    !ready_o ##[1:NVM_MAX] ready_o;
  endsequence

  a_key_gate: assert property (wr_i && addr_i == 8'h64 && wdata_i[31:24] != 8'h5a && ready_o
    |=> ready_o && !prog_start_o && !erase_start_o) else $error("unkeyed command started work");
  a_zero_idle: assert property (s_take ##0 wdata_i[3:0] == 4'h0 |=> ready_o && !prog_start_o)
    else $error("empty command started work");
  a_reserved_idle: assert property (s_take ##0 !(wdata_i[3:0] inside
    {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hb, 4'hd, 4'hf}) |=> ready_o) else $error("reserved code ran");
  a_nvm_busy: assert property (s_take ##0 wdata_i[3:0] inside {4'h2, 4'h4, 4'hf} |=> s_busy_nvm)
    else $error("lock or security command busy span wrong");
  a_prog_page: assert property (s_take ##0 wdata_i[3:0] inside {4'h1, 4'h3}
    |=> ready_o || (prog_start_o && page_o == page_held)) else $error("program start or page wrong");
  a_prog_time: assert property (prog_start_o |-> !ready_o ##[1:PROG_MAX] ready_o)
    else $error("program busy span wrong");
  a_erase_time: assert property (erase_start_o |-> !ready_o ##[1:ERASE_MAX] ready_o)
    else $error("erase busy span wrong");
  a_busy_deaf: assert property (wr_i && addr_i == 8'h64 && !ready_o |=> !prog_start_o && !erase_start_o)
    else $error("command taken while busy");
  a_status_ready: assert property (rd_i && addr_i == 8'h68 |=> rdata_o[0] == $past(ready_o))
    else $error("status ready bit wrong");
  a_irq_masked: assert property (wr_i && addr_i == 8'h60 && !wdata_i[0] && !wdata_i[2] && !wdata_i[3]
    |=> !irq_o) else $error("interrupt raised with all enables off");
endmodule

bind flash_command_status_unit flash_cmd_checker #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
  .NVM_CYCLES(NVM_CYCLES)) flash_cmd_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ready_o(ready_o), .irq_o(irq_o),
  .prog_start_o(prog_start_o), .erase_start_o(erase_start_o), .page_o(page_o));
`default_nettype wire

// File: flash_command_status_unit_tb.sv
// self-checking bench of the flash command unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic ready_o, irq_o, prog_start_o, erase_start_o;
  logic [9:0] page_o;
  int failures = 0;
  int n_compared = 0;
  // expected persistent state and flags
  logic [15:0] locks = 16'h0;
  logic [2:0] gp = 3'h0;
  logic sec = 1'b0;
  logic lerr = 1'b0;
  logic perr = 1'b0;
  logic [31:0] d;

  // short counts keep program and erase waits small
  flash_command_status_unit #(.PROG_CYCLES(5), .ERASE_CYCLES(7), .NVM_CYCLES(3)) flash_command_status_unit_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .ready_o(ready_o), .irq_o(irq_o), .prog_start_o(prog_start_o),
    .erase_start_o(erase_start_o), .page_o(page_o));

  always #4 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  // one-cycle strobes; the trailing delay lets the taking edge settle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic cmd(input logic [9:0] p, input logic [3:0] c);
    wr(8'h64, {8'h5a, 6'h0, p, 4'h0, c});
  endtask

  // bounded wait for idle
  task automatic idle();
    for (int i = 0; i < 40 && ready_o !== 1'b1; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk(ready_o, 1'b1);
  endtask

  // status read against tracked state; the read clears both error flags
  task automatic st();
    rd(8'h68);
    chk(d, {locks, 5'h0, gp, 3'h0, sec, perr, lerr, 1'b0, 1'b1});
    lerr = 1'b0;
    perr = 1'b0;
  endtask

  task automatic t_reset();
    st();
    chk(irq_o, 1'b0);
    wr(8'h60, 32'hffff_ffff);
    rd(8'h60);
    chk(d, 32'h0000_000d);
    rd(8'h6c);
    chk(d, 32'h0);
    wr(8'h60, 32'h0);
  endtask

  // lock via one page, unlock via another page of the same region
  task automatic t_lock();
    cmd(10'h0c5, 4'h2);
    chk(ready_o, 1'b0);
    idle();
    cmd(10'h3ff, 4'h2);
    idle();
    locks = 16'h8008;
    st();
    cmd(10'h0ff, 4'h4);
    idle();
    locks[3] = 1'b0;
    st();
  endtask

  // a command issued while busy must be dropped
  task automatic t_prog();
    cmd(10'h123, 4'h1);
    chk({prog_start_o, page_o}, {1'b1, 10'h123});
    cmd(10'h3c0, 4'h4);
    idle();
    cmd(10'h2c0, 4'h3);
    chk({prog_start_o, page_o}, {1'b1, 10'h2c0});
    idle();
    locks[11] = 1'b1;
    st();
    cmd(10'h2ff, 4'h1);
    chk({ready_o, prog_start_o}, 2'b10);
    lerr = 1'b1;
    st();
    st();
  endtask

  task automatic t_erase();
    cmd(10'h3ff, 4'h8);
    chk({ready_o, erase_start_o}, 2'b10);
    lerr = 1'b1;
    st();
    cmd(10'h2c0, 4'h4);
    idle();
    cmd(10'h3c0, 4'h4);
    idle();
    locks = 16'h0;
    cmd(10'h3ff, 4'h8);
    chk({ready_o, erase_start_o}, 2'b01);
    idle();
    st();
  endtask

  task automatic t_gp_sec();
    for (int i = 0; i < 3; i++)
    begin
      cmd(10'(i), 4'hb);
      idle();
      gp[i] = 1'b1;
      st();
    end
    cmd(10'h001, 4'hd);
    idle();
    gp[1] = 1'b0;
    cmd(10'h003, 4'hd);
    chk(ready_o, 1'b1);
    cmd(10'h003, 4'hb);
    chk(ready_o, 1'b1);
    st();
    cmd(10'h155, 4'hf);
    idle();
    sec = 1'b1;
    st();
  endtask

  // every reserved code, then a bad key followed by an empty command
  task automatic t_err();
    logic [3:0] bad [7] = '{4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hc, 4'he};
    foreach (bad[i])
    begin
      cmd(10'h0, bad[i]);
      chk(ready_o, 1'b1);
      perr = 1'b1;
      st();
    end
    // an empty command alone must not raise the programming error
    cmd(10'h3ff, 4'h0);
    st();
    wr(8'h64, 32'ha500_0002);
    chk(ready_o, 1'b1);
    cmd(10'h0, 4'h0);
    chk(ready_o, 1'b1);
    perr = 1'b1;
    st();
  endtask

  task automatic t_irq();
    wr(8'h60, 32'h0000_0001);
    chk(irq_o, 1'b1);
    cmd(10'h040, 4'h2);
    chk(irq_o, 1'b0);
    idle();
    locks[1] = 1'b1;
    chk(irq_o, 1'b1);
    wr(8'h60, 32'h0000_0008);
    chk(irq_o, 1'b0);
    cmd(10'h0, 4'h7);
    chk(irq_o, 1'b1);
    perr = 1'b1;
    st();
    chk(irq_o, 1'b0);
    wr(8'h60, 32'h0000_0004);
    cmd(10'h040, 4'h1);
    chk(irq_o, 1'b1);
    lerr = 1'b1;
    st();
    chk(irq_o, 1'b0);
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_lock();
    t_prog();
    t_erase();
    t_gp_sec();
    t_err();
    t_irq();
    test_done();
  end

  // the whole run needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
